// *** rtl/ccr_pkg.sv ***
package ccr_pkg;
    // execution times in states
    localparam int unsigned ST_CALL_REG  = 6;
    localparam int unsigned ST_CALL_ABS  = 8;
    localparam int unsigned ST_CALL_IND  = 8;
    localparam int unsigned ST_RET_SUB   = 8;
    localparam int unsigned ST_RET_EXC   = 10;
    localparam int unsigned ST_SLEEP     = 2;
    localparam int unsigned ST_NOP       = 2;
    localparam int unsigned ST_MOVE_BASE = 9;
    localparam int unsigned ST_MOVE_BYTE = 4;
    // reset values
    localparam logic [15:0] SP_RESET     = 16'hFF80;
    localparam logic [15:0] PC_RESET     = 16'h0000;
    localparam logic [7:0]  FLAGS_RESET  = 8'h80;
    // flag bit positions in the condition flags byte
    localparam int unsigned FLAG_C = 0;
    localparam int unsigned FLAG_V = 1;
    localparam int unsigned FLAG_Z = 2;
    localparam int unsigned FLAG_N = 3;
    localparam int unsigned FLAG_H = 5;
    // half-carry position for word arithmetic
    localparam int unsigned HALF_BIT = 11;

    typedef enum logic [2:0] {
        CCR_OP_NOP,
        CCR_OP_SLEEP,
        CCR_OP_CALL_REG,
        CCR_OP_CALL_ABS,
        CCR_OP_CALL_IND,
        CCR_OP_RET_SUB,
        CCR_OP_RET_EXC,
        CCR_OP_MOVE
    } ccr_op_t;
endpackage : ccr_pkg

// *** rtl/ccr_mem_if.sv ***
`timescale 1ns/1ns
interface ccr_mem_if;
    logic        req;
    logic        we;
    logic        word;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    modport core (output req, output we, output word, output addr, output wdata,
                  input rdata);
    modport port (input req, input we, input word, input addr, input wdata,
                  output rdata);
endinterface : ccr_mem_if

// *** rtl/ccr_mem_port.sv ***
`timescale 1ns/1ns
module ccr_mem_port
(
    // clock and reset
    input  wire logic   i_clk,
    input  wire logic   i_sys_rst,
    // core side
    ccr_mem_if.port     mif,
    // memory pins
    output logic        o_mem_req,
    output logic        o_mem_we,
    output logic        o_mem_word,
    output logic [15:0] o_mem_addr,
    output logic [15:0] o_mem_wdata,
    input  wire logic [15:0] i_mem_rdata
);
    logic        req_d,  req_q;
    logic        we_d,   we_q;
    logic        word_d, word_q;
    logic [15:0] addr_d, addr_q;
    logic [15:0] wd_d,   wd_q;

    // registers the access so memory pins come from flip-flops
    always_comb
    begin
        req_d  = mif.req;
        we_d   = mif.req & mif.we;
        word_d = mif.word;
        addr_d = mif.req ? mif.addr : addr_q;
        wd_d   = mif.req ? mif.wdata : wd_q;
    end

    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            req_q  <= 1'b0;
            we_q   <= 1'b0;
            word_q <= 1'b0;
            addr_q <= 16'h0000;
            wd_q   <= 16'h0000;
        end
        else
        begin
            req_q  <= req_d;
            we_q   <= we_d;
            word_q <= word_d;
            addr_q <= addr_d;
            wd_q   <= wd_d;
        end
    end

    assign o_mem_req   = req_q;
    assign o_mem_we    = we_q;
    assign o_mem_word  = word_q;
    assign o_mem_addr  = addr_q;
    assign o_mem_wdata = wd_q;
    assign mif.rdata   = i_mem_rdata;
endmodule : ccr_mem_port

// *** rtl/ccr_exec.sv ***
// How it works
// - register call: push pc, load register, 6
// - absolute call: push pc, load address, 8
// - indirect call: push pc, load vector word, 8
// - return: pop pc, flags kept, 8 states
// - exception return: pop flags then pc, 10
// - sleep: enter sleep, flags kept, 2 states
// - block move copies bytes until count zero
// - block move takes 4n plus 9 states
// - half carry from bit 11 carry/borrow
// - zero result keeps zero flag, else clear
// - decimal adjust carry sets, else keeps
// - divide flags: negative divisor, zero divisor
`timescale 1ns/1ns
module ccr_exec
    import ccr_pkg::*;
(
    // clock and reset
    input  wire logic          i_clk,
    input  wire logic          i_sys_rst,
    // instruction issue
    input  wire logic          i_start,
    input  wire ccr_pkg::ccr_op_t i_op,
    input  wire logic [15:0]   i_operand,
    input  wire logic          i_wake,
    output logic               o_busy,
    output logic               o_done,
    output logic               o_sleep,
    // architectural state
    output logic [15:0]        o_pc,
    output logic [15:0]        o_sp,
    output logic [7:0]         o_flags,
    output logic [7:0]         o_move_count_byte,
    output logic [15:0]        o_move_source_pointer,
    output logic [15:0]        o_move_dest_pointer,
    input  wire logic          i_load_move,
    input  wire logic [7:0]    i_move_count_byte,
    input  wire logic [15:0]   i_move_source_pointer,
    input  wire logic [15:0]   i_move_dest_pointer,
    // flag evaluation helpers
    input  wire logic [15:0]   i_alu_a,
    input  wire logic [15:0]   i_alu_b,
    input  wire logic          i_alu_sub,
    input  wire logic          i_alu_zero,
    input  wire logic          i_daa_carry,
    input  wire logic [7:0]    i_divisor,
    output logic               o_half_carry,
    output logic               o_zero_keep,
    output logic               o_daa_c,
    output logic               o_div_neg,
    output logic               o_div_zero,
    // memory pins
    output logic               o_mem_req,
    output logic               o_mem_we,
    output logic               o_mem_word,
    output logic [15:0]        o_mem_addr,
    output logic [15:0]        o_mem_wdata,
    input  wire logic [15:0]   i_mem_rdata
);
    import ccr_pkg::*;

    typedef enum {
        CCR_IDLE,
        CCR_RUN,
        CCR_SLEEPING
    } ccr_state_t;

    ccr_mem_if mif ();

    ccr_state_t  st_d,   st_q;
    ccr_op_t     op_d,   op_q;
    logic [15:0] cnt_d,  cnt_q;
    logic [15:0] len_d,  len_q;
    logic [15:0] opd_d,  opd_q;
    logic [15:0] pc_d,   pc_q;
    logic [15:0] sp_d,   sp_q;
    logic [7:0]  fl_d,   fl_q;
    logic [7:0]  mc_d,   mc_q;
    logic [15:0] ms_d,   ms_q;
    logic [15:0] md_d,   md_q;
    logic [7:0]  byte_d, byte_q;
    logic        done_d, done_q;
    logic [16:0] low12;
    logic [15:0] ret_pc;

    ccr_mem_port u_port
    (
        .i_clk       (i_clk),
        .i_sys_rst   (i_sys_rst),
        .mif         (mif),
        .o_mem_req   (o_mem_req),
        .o_mem_we    (o_mem_we),
        .o_mem_word  (o_mem_word),
        .o_mem_addr  (o_mem_addr),
        .o_mem_wdata (o_mem_wdata),
        .i_mem_rdata (i_mem_rdata)
    );

    // bit 12 of the low 12-bit sum/difference is the carry or borrow
    assign low12        = i_alu_sub ? ({5'h00, i_alu_a[11:0]} - {5'h00, i_alu_b[11:0]})
                                    : ({5'h00, i_alu_a[11:0]} + {5'h00, i_alu_b[11:0]});
    assign o_half_carry = low12[HALF_BIT + 1];
    assign o_zero_keep  = i_alu_zero ? fl_q[FLAG_Z] : 1'b0;
    assign o_daa_c      = i_daa_carry | fl_q[FLAG_C];
    assign o_div_neg    = i_divisor[7];
    assign o_div_zero   = (i_divisor == 8'h00);
    assign ret_pc       = pc_q + 16'h0002;

    // memory access per state count
    always_comb
    begin
        mif.req   = 1'b0;
        mif.we    = 1'b0;
        mif.word  = 1'b1;
        mif.addr  = 16'h0000;
        mif.wdata = 16'h0000;
        if (st_q == CCR_RUN)
        begin
            unique case (op_q)
                CCR_OP_CALL_REG, CCR_OP_CALL_ABS, CCR_OP_CALL_IND:
                begin
                    if (cnt_q == 16'h0001)
                    begin
                        mif.req   = 1'b1;
                        mif.we    = 1'b1;
                        mif.addr  = sp_q - 16'h0002;
                        mif.wdata = ret_pc;
                    end
                    else if (op_q == CCR_OP_CALL_IND && cnt_q == 16'h0003)
                    begin
                        mif.req  = 1'b1;
                        mif.addr = {8'h00, opd_q[7:0]};
                    end
                end
                CCR_OP_RET_SUB, CCR_OP_RET_EXC:
                begin
                    // exception return reads flags first, then the pc word
                    if (cnt_q == 16'h0001 || (op_q == CCR_OP_RET_EXC && cnt_q == 16'h0004))
                    begin
                        mif.req  = 1'b1;
                        mif.addr = sp_q;
                    end
                end
                CCR_OP_MOVE:
                begin
                    if (mc_q != 8'h00 && cnt_q >= 16'h0005 && cnt_q[1:0] == 2'b01)
                    begin
                        mif.req  = 1'b1;
                        mif.word = 1'b0;
                        mif.addr = ms_q;
                    end
                    else if (mc_q != 8'h00 && cnt_q >= 16'h0005 && cnt_q[1:0] == 2'b00)
                    begin
                        mif.req   = 1'b1;
                        mif.we    = 1'b1;
                        mif.word  = 1'b0;
                        mif.addr  = md_q;
                        mif.wdata = {8'h00, byte_q};
                    end
                end
                default:
                begin
                end
            endcase
        end
    end

    always_comb
    begin
        st_d   = st_q;
        op_d   = op_q;
        cnt_d  = cnt_q;
        len_d  = len_q;
        opd_d  = opd_q;
        pc_d   = pc_q;
        sp_d   = sp_q;
        fl_d   = fl_q;
        mc_d   = mc_q;
        ms_d   = ms_q;
        md_d   = md_q;
        byte_d = byte_q;
        done_d = 1'b0;
        if (i_load_move && st_q == CCR_IDLE)
        begin
            mc_d = i_move_count_byte;
            ms_d = i_move_source_pointer;
            md_d = i_move_dest_pointer;
        end
        unique case (st_q)
            CCR_IDLE:
            begin
                if (i_start)
                begin
                    st_d  = CCR_RUN;
                    op_d  = i_op;
                    opd_d = i_operand;
                    cnt_d = 16'h0001;
                    unique case (i_op)
                        CCR_OP_NOP:      len_d = 16'(ST_NOP);
                        CCR_OP_SLEEP:    len_d = 16'(ST_SLEEP);
                        CCR_OP_CALL_REG: len_d = 16'(ST_CALL_REG);
                        CCR_OP_CALL_ABS: len_d = 16'(ST_CALL_ABS);
                        CCR_OP_CALL_IND: len_d = 16'(ST_CALL_IND);
                        CCR_OP_RET_SUB:  len_d = 16'(ST_RET_SUB);
                        CCR_OP_RET_EXC:  len_d = 16'(ST_RET_EXC);
                        CCR_OP_MOVE:     len_d = 16'(ST_MOVE_BYTE) * {8'h00, i_load_move ?
                                                 i_move_count_byte : mc_q}
                                                 + 16'(ST_MOVE_BASE);
                    endcase
                end
            end
            CCR_RUN:
            begin
                cnt_d = cnt_q + 16'h0001;
                unique case (op_q)
                    CCR_OP_CALL_REG, CCR_OP_CALL_ABS:
                        if (cnt_q == 16'h0001)
                            sp_d = sp_q - 16'h0002;
                    CCR_OP_CALL_IND:
                    begin
                        if (cnt_q == 16'h0001)
                            sp_d = sp_q - 16'h0002;
                        // read data stands two states after the request
                        if (cnt_q == 16'h0005)
                            opd_d = mif.rdata;
                    end
                    CCR_OP_RET_SUB:
                        if (cnt_q == 16'h0003)
                        begin
                            opd_d = mif.rdata;
                            sp_d  = sp_q + 16'h0002;
                        end
                    CCR_OP_RET_EXC:
                        if (cnt_q == 16'h0003)
                        begin
                            fl_d = mif.rdata[7:0];
                            sp_d = sp_q + 16'h0002;
                        end
                        else if (cnt_q == 16'h0006)
                        begin
                            opd_d = mif.rdata;
                            sp_d  = sp_q + 16'h0002;
                        end
                    CCR_OP_MOVE:
                        if (mc_q != 8'h00 && cnt_q >= 16'h0005)
                        begin
                            if (cnt_q[1:0] == 2'b11)
                                byte_d = mif.rdata[7:0];
                            else if (cnt_q[1:0] == 2'b00)
                            begin
                                ms_d = ms_q + 16'h0001;
                                md_d = md_q + 16'h0001;
                                mc_d = mc_q - 8'h01;
                            end
                        end
                    default:
                    begin
                    end
                endcase
                if (cnt_q == len_q)
                begin
                    done_d = 1'b1;
                    st_d   = CCR_IDLE;
                    unique case (op_q)
                        CCR_OP_CALL_REG, CCR_OP_CALL_ABS, CCR_OP_CALL_IND,
                        CCR_OP_RET_SUB, CCR_OP_RET_EXC:
                            pc_d = opd_q;
                        CCR_OP_SLEEP:
                        begin
                            pc_d = ret_pc;
                            st_d = CCR_SLEEPING;
                        end
                        default:
                            pc_d = ret_pc;
                    endcase
                end
            end
            CCR_SLEEPING:
            begin
                if (i_wake)
                    st_d = CCR_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            st_q   <= CCR_IDLE;
            op_q   <= CCR_OP_NOP;
            cnt_q  <= 16'h0000;
            len_q  <= 16'h0000;
            opd_q  <= 16'h0000;
            pc_q   <= PC_RESET;
            sp_q   <= SP_RESET;
            fl_q   <= FLAGS_RESET;
            mc_q   <= 8'h00;
            ms_q   <= 16'h0000;
            md_q   <= 16'h0000;
            byte_q <= 8'h00;
            done_q <= 1'b0;
        end
        else
        begin
            st_q   <= st_d;
            op_q   <= op_d;
            cnt_q  <= cnt_d;
            len_q  <= len_d;
            opd_q  <= opd_d;
            pc_q   <= pc_d;
            sp_q   <= sp_d;
            fl_q   <= fl_d;
            mc_q   <= mc_d;
            ms_q   <= ms_d;
            md_q   <= md_d;
            byte_q <= byte_d;
            done_q <= done_d;
        end
    end

    assign o_busy                = (st_q == CCR_RUN);
    assign o_done                = done_q;
    assign o_sleep               = (st_q == CCR_SLEEPING);
    assign o_pc                  = pc_q;
    assign o_sp                  = sp_q;
    assign o_flags               = fl_q;
    assign o_move_count_byte     = mc_q;
    assign o_move_source_pointer = ms_q;
    assign o_move_dest_pointer   = md_q;

    // done is registered, so it is sampled one edge after the last state
    sequence s_call_issue;
        st_q == CCR_IDLE && i_start && i_op == CCR_OP_CALL_REG;
    endsequence

    sequence s_move_end;
        st_q == CCR_RUN && op_q == CCR_OP_MOVE && cnt_q == len_q;
    endsequence

    a_call_reg_time: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        s_call_issue |-> ##7 done_q)
        else $error("register call not done in 6 states");
    a_call_abs_time: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (st_q == CCR_IDLE && i_start && i_op == CCR_OP_CALL_ABS) |-> ##9 done_q)
        else $error("absolute call not done in 8 states");
    a_call_sp_dec: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (st_q == CCR_IDLE && i_start && i_op == CCR_OP_CALL_IND)
        |-> ##2 (sp_q == $past(sp_q, 2) - 16'h0002))
        else $error("indirect call stack not lowered by two");
    a_call_ind_time: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (st_q == CCR_IDLE && i_start && i_op == CCR_OP_CALL_IND) |-> ##9 done_q)
        else $error("indirect call not done in 8 states");
    a_ret_flags_kept: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (st_q == CCR_IDLE && i_start && i_op == CCR_OP_RET_SUB)
        |-> ##9 (done_q && fl_q == $past(fl_q, 9)))
        else $error("return changed flags or timing");
    a_rte_time: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (st_q == CCR_IDLE && i_start && i_op == CCR_OP_RET_EXC) |-> ##11 done_q)
        else $error("exception return not done in 10 states");
    a_sleep_enter: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (st_q == CCR_IDLE && i_start && i_op == CCR_OP_SLEEP)
        |-> ##3 (o_sleep && fl_q == $past(fl_q, 3)))
        else $error("sleep not entered in 2 states");
    a_move_count_step: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (mc_q != $past(mc_q) && !$past(i_load_move))
        |-> (mc_q == $past(mc_q) - 8'h01 && ms_q == $past(ms_q) + 16'h0001))
        else $error("block move step wrong");
    a_move_finish: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        s_move_end |-> mc_q == 8'h00)
        else $error("block move ended with bytes left");
    a_move_len: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (st_q == CCR_RUN && op_q == CCR_OP_MOVE && cnt_q == 16'h0001)
        |-> len_q == 16'(ST_MOVE_BYTE) * {8'h00, mc_q} + 16'(ST_MOVE_BASE))
        else $error("block move length wrong");
    a_nop_pc: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (st_q == CCR_IDLE && i_start && i_op == CCR_OP_NOP)
        |-> ##3 (done_q && pc_q == $past(pc_q, 3) + 16'h0002))
        else $error("no-op did not advance pc by two");
endmodule : ccr_exec

// *** tb/ccr_mem_model.sv ***
`timescale 1ns/1ns
module ccr_mem_model
(
    // clock
    input  wire logic        i_clk,
    // memory pins of the core
    input  wire logic        i_req,
    input  wire logic        i_we,
    input  wire logic        i_word,
    input  wire logic [15:0] i_addr,
    input  wire logic [15:0] i_wdata,
    output logic [15:0]      o_rdata
);
    logic [15:0] mem [logic [15:0]];
    logic [15:0] data_q  = 16'h0000;
    logic        valid_q = 1'b0;

    function automatic logic [15:0] peek(input logic [15:0] a);
        if (mem.exists(a))
        begin
            return mem[a];
        end
        return 16'h0000;
    endfunction : peek

    task automatic poke(input logic [15:0] a, input logic [15:0] d);
        mem[a] = d;
    endtask : poke

    // bytes travel in the low lane; read data shows in the cycle after the request
    always @(posedge i_clk)
    begin
        valid_q <= i_req && !i_we;
        if (i_req && i_we)
        begin
            mem[i_addr] = i_word ? i_wdata : {8'h00, i_wdata[7:0]};
        end
        if (i_req && !i_we)
        begin
            data_q <= peek(i_addr) & (i_word ? 16'hFFFF : 16'h00FF);
        end
    end

    // outside the answer cycle the data lines show no stale value
    assign o_rdata = valid_q ? data_q : ~data_q;
endmodule : ccr_mem_model

// *** tb/cpu_call_return_block_move_tb.sv ***
`timescale 1ns/1ns
module cpu_call_return_block_move_tb;
    import ccr_pkg::*;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic start = 1'b0;
    ccr_op_t op = CCR_OP_NOP;
    logic [15:0] operand = 16'h0000;
    logic wake = 1'b0;
    logic load = 1'b0;
    logic [7:0] ld_cnt = 8'h00;
    logic [15:0] ld_src = 16'h0000;
    logic [15:0] ld_dst = 16'h0000;
    logic [15:0] alu_a = 16'h0000;
    logic [15:0] alu_b = 16'h0000;
    logic alu_sub = 1'b0;
    logic alu_zero = 1'b0;
    logic daa_carry = 1'b0;
    logic [7:0] divisor = 8'h00;
    logic busy, done, sleep, half_c, zero_k, daa_c, div_n, div_z;
    logic mreq, mwe, mword;
    logic [15:0] pc, sp, src, dst, maddr, mwdata, mrdata;
    logic [7:0] flags, cnt;
    int tests_run = 0;
    int fail_count = 0;

    always #4 i_clk = ~i_clk;

    ccr_exec DUT (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_start(start), .i_op(op),
        .i_operand(operand), .i_wake(wake), .o_busy(busy), .o_done(done), .o_sleep(sleep),
        .o_pc(pc), .o_sp(sp), .o_flags(flags), .o_move_count_byte(cnt),
        .o_move_source_pointer(src), .o_move_dest_pointer(dst), .i_load_move(load),
        .i_move_count_byte(ld_cnt), .i_move_source_pointer(ld_src),
        .i_move_dest_pointer(ld_dst), .i_alu_a(alu_a), .i_alu_b(alu_b), .i_alu_sub(alu_sub),
        .i_alu_zero(alu_zero), .i_daa_carry(daa_carry), .i_divisor(divisor),
        .o_half_carry(half_c), .o_zero_keep(zero_k), .o_daa_c(daa_c), .o_div_neg(div_n),
        .o_div_zero(div_z), .o_mem_req(mreq), .o_mem_we(mwe), .o_mem_word(mword),
        .o_mem_addr(maddr), .o_mem_wdata(mwdata), .i_mem_rdata(mrdata));

    ccr_mem_model u_mem (.i_clk(i_clk), .i_req(mreq), .i_we(mwe), .i_word(mword),
        .i_addr(maddr), .i_wdata(mwdata), .o_rdata(mrdata));

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up

    // issue one operation and count the cycles until its done pulse
    task automatic run_op(input ccr_op_t o, input logic [15:0] opd, input int unsigned states);
        int unsigned k;
        k = 0;
        @(negedge i_clk);
        start = 1'b1;
        op = o;
        operand = opd;
        @(negedge i_clk);
        start = 1'b0;
        while (k < 1000)
        begin
            @(posedge i_clk);
            #1;
            k++;
            if (done === 1'b1)
                break;
        end
        check("states", 16'(k), 16'(states));
    endtask : run_op

    task automatic t_reset;
        check("pc", pc, PC_RESET);
        check("sp", sp, SP_RESET);
        check("flags", {8'h00, flags}, {8'h00, FLAGS_RESET});
    endtask : t_reset

    task automatic t_nop;
        run_op(CCR_OP_NOP, 16'h0000, 2);
        check("nop pc", pc, 16'h0002);
        check("nop sp", sp, SP_RESET);
    endtask : t_nop

    // every call kind followed by a return; the pushed word is the pc plus two
    task automatic t_calls;
        u_mem.poke(16'h0030, 16'h5678);
        run_op(CCR_OP_CALL_REG, 16'h1234, 6);
        check("reg pc", pc, 16'h1234);
        check("reg sp", sp, 16'hFF7E);
        check("reg push", u_mem.peek(16'hFF7E), 16'h0004);
        run_op(CCR_OP_RET_SUB, 16'h0000, 8);
        check("ret pc", pc, 16'h0004);
        check("ret sp", sp, 16'hFF80);
        check("ret flags", {8'h00, flags}, {8'h00, FLAGS_RESET});
        run_op(CCR_OP_CALL_ABS, 16'h4000, 8);
        check("abs pc", pc, 16'h4000);
        check("abs sp", sp, 16'hFF7E);
        check("abs push", u_mem.peek(16'hFF7E), 16'h0006);
        run_op(CCR_OP_RET_SUB, 16'h0000, 8);
        check("ret1 pc", pc, 16'h0006);
        run_op(CCR_OP_CALL_IND, 16'h0030, 8);
        check("ind pc", pc, 16'h5678);
        check("ind sp", sp, 16'hFF7E);
        check("ind push", u_mem.peek(16'hFF7E), 16'h0008);
        run_op(CCR_OP_RET_SUB, 16'h0000, 8);
        check("ret2 pc", pc, 16'h0008);
    endtask : t_calls

    task automatic t_ret_exc;
        u_mem.poke(16'hFF80, 16'h8585);
        u_mem.poke(16'hFF82, 16'h2222);
        run_op(CCR_OP_RET_EXC, 16'h0000, 10);
        check("rte flags", {8'h00, flags}, 16'h0085);
        check("rte pc", pc, 16'h2222);
        check("rte sp", sp, 16'hFF84);
    endtask : t_ret_exc

    // f is the flags byte that the core holds at the time of the call
    task automatic t_flags(input logic [7:0] f);
        logic [12:0] s;
        logic        hc;
        for (int i = 0; i < 4; i++)
        begin
            @(negedge i_clk);
            alu_a = (i < 2) ? 16'h0800 : 16'h1000;
            alu_b = (i[0]) ? 16'h07FF : 16'h0800;
            alu_sub = (i >= 2);
            alu_zero = i[0];
            daa_carry = i[1];
            divisor = (i == 0) ? 8'h00 : ((i == 1) ? 8'h80 : 8'h7F);
            #1;
            s = {1'b0, alu_a[11:0]} + {1'b0, alu_b[11:0]};
            hc = alu_sub ? (alu_a[11:0] < alu_b[11:0]) : s[12];
            check("half", {15'h0, half_c}, {15'h0, hc});
            check("zkeep", {15'h0, zero_k}, {15'h0, alu_zero & f[FLAG_Z]});
            check("daa", {15'h0, daa_c}, {15'h0, daa_carry | f[FLAG_C]});
            check("dneg", {15'h0, div_n}, {15'h0, divisor[7]});
            check("dzero", {15'h0, div_z}, {15'h0, divisor == 8'h00});
        end
    endtask : t_flags

    task automatic t_sleep;
        run_op(CCR_OP_SLEEP, 16'h0000, 2);
        check("sleep", {15'h0, sleep}, 16'h0001);
        check("sleep flags", {8'h00, flags}, 16'h0085);
        @(negedge i_clk);
        start = 1'b1;
        repeat (4) @(negedge i_clk);
        start = 1'b0;
        check("asleep busy", {15'h0, busy}, 16'h0000);
        check("asleep pc", pc, 16'h2224);
        wake = 1'b1;
        @(negedge i_clk);
        wake = 1'b0;
        check("woken", {15'h0, sleep}, 16'h0000);
    endtask : t_sleep

    task automatic t_move(input logic [7:0] n);
        logic [15:0] exp_b;
        @(negedge i_clk);
        load = 1'b1;
        ld_cnt = n;
        ld_src = 16'h1000;
        ld_dst = 16'h2000;
        for (int i = 0; i < 3; i++)
            u_mem.poke(16'h1000 + 16'(i), 16'h0011 * 16'(i + 1));
        @(negedge i_clk);
        load = 1'b0;
        run_op(CCR_OP_MOVE, 16'h0000, 4 * n + 9);
        check("count", {8'h00, cnt}, 16'h0000);
        check("src", src, 16'h1000 + 16'(n));
        check("dst", dst, 16'h2000 + 16'(n));
        for (int i = 0; i < 3; i++)
        begin
            exp_b = (i < n) ? 16'h0011 * 16'(i + 1) : 16'h0000;
            check("copy", u_mem.peek(16'h2000 + 16'(i)) & 16'h00FF, exp_b);
        end
    endtask : t_move

    initial
    begin
        #20000;
        fail_count++;
        wrap_up();
    end

    initial
    begin
        repeat (10) @(negedge i_clk);
        i_sys_rst = 1'b0;
        t_reset();
        t_flags(FLAGS_RESET);
        t_nop();
        t_calls();
        t_ret_exc();
        t_flags(8'h85);
        t_sleep();
        t_move(8'h00);
        t_move(8'h03);
        wrap_up();
    end
endmodule : cpu_call_return_block_move_tb
